// ===== logic/circ_addr_ctrl.sv
// circular-buffer address control with APB registers
// Summary of operation
// [R01] one X-space buffer and one independent Y-space buffer operate at the same time.
// [R02] circular addressing serves data and program accesses, program ones using the X pointers.
// [R03] any pointer number may be selected; software should avoid frame and stack pointers. Here select 15, the stack pointer, disables circular mode instead.
// [R04] software sets up a general buffer for one direction with an aligned start or end.
// [R05] power-of-two buffers get both boundaries checked so they work in both directions.
// [R06] start and end of each space live in four separate 16-bit boundary registers.
// [R07] Y-space addresses are word addresses with the lowest bit forced to zero.
// [R08] length is never stored and follows from start and end of the same space.
// [R09] the largest buffer is 32K words, that is 64 Kbytes.
// [R10] control bits 3 to 0 pick the pointer used for X circular addressing.
// [R11] X circular addressing runs only with a non-all-ones select and control bit 15 set.
// [R12] an all-ones X select disables circular addressing in both X read and X write generators.
// [R13] control bits 7 to 4 pick the pointer used for Y circular addressing.
// [R14] Y circular addressing runs only with a non-all-ones select and control bit 14 set.
// [R15] an incrementing pointer past the end reloads start; a decrementing one below start reloads end.
`timescale 1ns/1ps
module circ_addr_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // X read generator
    input  wire logic [3:0]  x_rd_ptr,
    input  wire logic        x_rd_prog,
    input  wire logic [15:0] x_rd_ea,
    input  wire logic [15:0] x_rd_step,
    input  wire logic        x_rd_dec,
    output logic      [15:0] x_rd_next,
    output logic             x_rd_wrapped,
    // X write generator
    input  wire logic [3:0]  x_wr_ptr,
    input  wire logic [15:0] x_wr_ea,
    input  wire logic [15:0] x_wr_step,
    input  wire logic        x_wr_dec,
    output logic      [15:0] x_wr_next,
    output logic             x_wr_wrapped,
    // Y generator, then the X and Y enable levels
    input  wire logic [3:0]  y_ptr,
    input  wire logic [15:0] y_ea,
    input  wire logic [15:0] y_step,
    input  wire logic        y_dec,
    output logic      [15:0] y_next,
    output logic             y_wrapped,
    output logic             x_active,
    output logic             y_active
);
    logic [15:0] circular_buffer_control;
    logic [15:0] x_buffer_start;
    logic [15:0] x_buffer_end;
    logic [15:0] y_buffer_start;
    logic [15:0] y_buffer_end;
    logic [15:0] next_circular_buffer_control;
    logic [15:0] next_x_buffer_start;
    logic [15:0] next_x_buffer_end;
    logic [15:0] next_y_buffer_start;
    logic [15:0] next_y_buffer_end;
    logic [31:0] next_prdata;
    logic        next_pslverr;
    logic [31:0] rd_q;
    logic [3:0]  x_pointer_select;
    logic [3:0]  y_pointer_select;
    logic        x_circular_enable;
    logic        y_circular_enable;
    logic        x_sel_ok;
    logic        y_sel_ok;
    logic        x_rd_hit;
    logic        x_wr_hit;
    logic        y_hit;
    logic [15:0] x_span;
    logic [15:0] y_span;
    logic        x_too_long;
    logic        y_too_long;
    logic        wr_access;
    logic        rd_access;
    logic        mapped;

    // zero wait states: every access completes in its first access cycle
    assign pready    = 1'b1;
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && penable && !pwrite;
    assign mapped    = (paddr == circ_pkg::OFS_CONTROL) || (paddr == circ_pkg::OFS_X_START)
                    || (paddr == circ_pkg::OFS_X_END) || (paddr == circ_pkg::OFS_Y_START)
                    || (paddr == circ_pkg::OFS_Y_END) || (paddr == circ_pkg::OFS_STATUS);

    assign x_pointer_select  = circular_buffer_control[circ_pkg::X_SEL_LSB +: 4];  // R10
    assign y_pointer_select  = circular_buffer_control[circ_pkg::Y_SEL_LSB +: 4];  // R13
    assign x_circular_enable = circular_buffer_control[circ_pkg::X_EN_BIT];
    assign y_circular_enable = circular_buffer_control[circ_pkg::Y_EN_BIT];
    assign x_sel_ok          = x_pointer_select != circ_pkg::SEL_NONE;  // R12
    assign y_sel_ok          = y_pointer_select != circ_pkg::SEL_NONE;
    assign x_active          = x_sel_ok && x_circular_enable;  // R11
    assign y_active          = y_sel_ok && y_circular_enable;  // R14
    // any of pointers 0 to 14 may match, frame pointer included; stack pointer 15 never matches
    assign x_rd_hit          = x_active && (x_rd_ptr == x_pointer_select);  // R03 R02
    assign x_wr_hit          = x_active && (x_wr_ptr == x_pointer_select);  // R12
    assign y_hit             = y_active && (y_ptr == y_pointer_select) && !x_rd_prog;  // R01

    // length only derived, never stored
    assign x_span     = x_buffer_end - x_buffer_start;  // R08
    assign y_span     = y_buffer_end - y_buffer_start;
    assign x_too_long = x_buffer_end < x_buffer_start;  // R09
    assign y_too_long = y_buffer_end < y_buffer_start;

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
        logic [15:0] r;
        r = old;
        if (be[0])
            r[7:0] = wd[7:0];
        if (be[1])
            r[15:8] = wd[15:8];
        return r;
    endfunction : merge16

    always_comb
    begin
        next_circular_buffer_control = circular_buffer_control;
        next_x_buffer_start          = x_buffer_start;
        next_x_buffer_end            = x_buffer_end;
        next_y_buffer_start          = y_buffer_start;
        next_y_buffer_end            = y_buffer_end;
        next_prdata                  = rd_q;
        next_pslverr                 = 1'b0;
        if (wr_access)
        begin
            unique case (paddr)
                circ_pkg::OFS_CONTROL:
                    next_circular_buffer_control = merge16(circular_buffer_control, pwdata, pstrb);
                circ_pkg::OFS_X_START: next_x_buffer_start = merge16(x_buffer_start, pwdata, pstrb);  // R06
                circ_pkg::OFS_X_END:   next_x_buffer_end   = merge16(x_buffer_end, pwdata, pstrb);
                circ_pkg::OFS_Y_START: next_y_buffer_start = merge16(y_buffer_start, pwdata, pstrb);
                circ_pkg::OFS_Y_END:   next_y_buffer_end   = merge16(y_buffer_end, pwdata, pstrb);
                default:               next_pslverr        = !mapped || (paddr == circ_pkg::OFS_STATUS);
            endcase
        end
        else if (rd_access)
        begin
            unique case (paddr)
                circ_pkg::OFS_CONTROL: next_prdata = {16'h0000, circular_buffer_control};
                circ_pkg::OFS_X_START: next_prdata = {16'h0000, x_buffer_start};
                circ_pkg::OFS_X_END:   next_prdata = {16'h0000, x_buffer_end};
                circ_pkg::OFS_Y_START: next_prdata = {16'h0000, y_buffer_start};
                circ_pkg::OFS_Y_END:   next_prdata = {16'h0000, y_buffer_end};
                circ_pkg::OFS_STATUS:
                    next_prdata = {x_span[15:1], y_span[15:1], x_too_long || y_too_long, x_active};
                default:
                begin
                    next_prdata  = 32'h0000_0000;
                    next_pslverr = 1'b1;
                end
            endcase
        end
    end

    // read data held in a flop; answer is valid in the access cycle via bypass
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            circular_buffer_control <= circ_pkg::CONTROL_RESET;
            x_buffer_start          <= circ_pkg::BOUND_RESET;
            x_buffer_end            <= circ_pkg::BOUND_RESET;
            y_buffer_start          <= circ_pkg::BOUND_RESET;
            y_buffer_end            <= circ_pkg::BOUND_RESET;
            rd_q                    <= 32'h0000_0000;
        end
        else
        begin
            circular_buffer_control <= next_circular_buffer_control;
            x_buffer_start          <= next_x_buffer_start;
            x_buffer_end            <= next_x_buffer_end;
            y_buffer_start          <= next_y_buffer_start;
            y_buffer_end            <= next_y_buffer_end;
            rd_q                    <= next_prdata;
        end
    end
    assign prdata  = (psel && penable) ? next_prdata : rd_q;
    assign pslverr = (psel && penable) ? next_pslverr : 1'b0;

    circ_wrap #(.AW(circ_pkg::ADDR_W), .WORD_ONLY(1'b0)) u_x_rd (
        .pclk       (pclk),
        .presetn    (presetn),
        .active     (x_rd_hit),
        .start_addr (x_buffer_start),
        .end_addr   (x_buffer_end),
        .ea_in      (x_rd_ea),
        .ea_step    (x_rd_step),
        .ea_dec     (x_rd_dec),
        .ea_out     (x_rd_next),
        .wrapped    (x_rd_wrapped)
    );

    circ_wrap #(.AW(circ_pkg::ADDR_W), .WORD_ONLY(1'b0)) u_x_wr (
        .pclk       (pclk),
        .presetn    (presetn),
        .active     (x_wr_hit),
        .start_addr (x_buffer_start),
        .end_addr   (x_buffer_end),
        .ea_in      (x_wr_ea),
        .ea_step    (x_wr_step),
        .ea_dec     (x_wr_dec),
        .ea_out     (x_wr_next),
        .wrapped    (x_wr_wrapped)
    );

    circ_wrap #(.AW(circ_pkg::ADDR_W), .WORD_ONLY(1'b1)) u_y (
        .pclk       (pclk),
        .presetn    (presetn),
        .active     (y_hit),
        .start_addr (y_buffer_start),
        .end_addr   (y_buffer_end),
        .ea_in      (y_ea),
        .ea_step    (y_step),
        .ea_dec     (y_dec),
        .ea_out     (y_next),
        .wrapped    (y_wrapped)
    );

    // a disabled space never reloads a boundary
    a_x_off_no_wrap: assert property (@(posedge pclk) disable iff (!presetn)  // R12
        !x_active |=> !x_rd_wrapped && !x_wr_wrapped) else $error("x wrapped while disabled");

    a_y_off_no_wrap: assert property (@(posedge pclk) disable iff (!presetn)  // R14
        !y_active |=> !y_wrapped) else $error("y wrapped while disabled");

    // enable levels follow the control fields
    a_x_act_def: assert property (@(posedge pclk) disable iff (!presetn)  // R11
        x_active == (circular_buffer_control[15] && circular_buffer_control[3:0] != 4'hf))
        else $error("x active mismatch");

    a_y_act_def: assert property (@(posedge pclk) disable iff (!presetn)  // R14
        y_active == (circular_buffer_control[14] && circular_buffer_control[7:4] != 4'hf))
        else $error("y active mismatch");

    a_y_word_lsb: assert property (@(posedge pclk) disable iff (!presetn)  // R07
        y_next[0] == 1'b0) else $error("y address odd");

    // x read generator: both boundaries
    a_x_inc_wrap: assert property (@(posedge pclk) disable iff (!presetn)  // R15
        x_rd_hit && !x_rd_dec && (x_rd_ea + x_rd_step > x_buffer_end) && (x_rd_ea + x_rd_step >= x_rd_ea)
        |=> x_rd_wrapped && x_rd_next == $past(x_buffer_start))
        else $error("x increment did not reload start");

    a_x_rd_dec_wrap: assert property (@(posedge pclk) disable iff (!presetn)  // R05
        x_rd_hit && x_rd_dec && (x_rd_ea - x_rd_step < x_buffer_start) && (x_rd_ea >= x_rd_step)
        |=> x_rd_wrapped && x_rd_next == $past(x_buffer_end))
        else $error("x read decrement did not reload end");

    // outside circular mode the step is plain arithmetic
    a_x_plain_step: assert property (@(posedge pclk) disable iff (!presetn)  // R11
        !x_active && !x_rd_dec |=> !x_rd_wrapped && x_rd_next == $past(x_rd_ea) + $past(x_rd_step))
        else $error("x read step wrong while disabled");

    // x write generator
    a_x_dec_wrap: assert property (@(posedge pclk) disable iff (!presetn)  // R15
        x_wr_hit && x_wr_dec && (x_wr_ea - x_wr_step < x_buffer_start) && (x_wr_ea >= x_wr_step)
        |=> x_wr_wrapped && x_wr_next == $past(x_buffer_end))
        else $error("x decrement did not reload end");

    a_x_wr_inc_wrap: assert property (@(posedge pclk) disable iff (!presetn)  // R15
        x_wr_hit && !x_wr_dec && (x_wr_ea + x_wr_step > x_buffer_end) && (x_wr_ea + x_wr_step >= x_wr_ea)
        |=> x_wr_wrapped && x_wr_next == $past(x_buffer_start))
        else $error("x write increment did not reload start");

    // y generator: word addresses, even steps only
    sequence s_y_inc_over;
        y_hit && !y_dec && !y_step[0] && ({y_ea[15:1], 1'b0} + y_step > {y_buffer_end[15:1], 1'b0})
        && ({y_ea[15:1], 1'b0} + y_step >= {y_ea[15:1], 1'b0});
    endsequence

    sequence s_y_start_loaded;
        y_wrapped && y_next == ($past(y_buffer_start) & 16'hfffe);
    endsequence

    sequence s_y_dec_under;
        y_hit && y_dec && !y_step[0] && ({y_ea[15:1], 1'b0} - y_step < {y_buffer_start[15:1], 1'b0})
        && ({y_ea[15:1], 1'b0} >= y_step);
    endsequence

    sequence s_y_end_loaded;
        y_wrapped && y_next == ($past(y_buffer_end) & 16'hfffe);
    endsequence

    a_y_inc_wrap: assert property (@(posedge pclk) disable iff (!presetn)  // R15
        s_y_inc_over |=> s_y_start_loaded) else $error("y increment did not reload start");

    a_y_dec_wrap: assert property (@(posedge pclk) disable iff (!presetn)  // R05
        s_y_dec_under |=> s_y_end_loaded) else $error("y decrement did not reload end");

    // program fetches steer only the x pointers
    a_prog_no_y: assert property (@(posedge pclk) disable iff (!presetn)  // R02
        x_rd_prog |=> !y_wrapped) else $error("y wrapped during program access");

    // register writes land at the end of the access cycle
    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)  // R10
        wr_access && paddr == circ_pkg::OFS_CONTROL && pstrb == 4'hf
        |=> circular_buffer_control == $past(pwdata[15:0]))
        else $error("control write lost");

    a_bound_write: assert property (@(posedge pclk) disable iff (!presetn)  // R06
        wr_access && paddr == circ_pkg::OFS_Y_END && pstrb == 4'hf
        |=> y_buffer_end == $past(pwdata[15:0])) else $error("boundary write lost");
endmodule : circ_addr_ctrl

// ===== common/circ_pkg.sv
// constants for the circular-buffer address control block
package circ_pkg;
    localparam int unsigned ADDR_W          = 16;
    localparam int unsigned SEL_W           = 4;
    // register byte offsets
    localparam logic [7:0]  OFS_CONTROL     = 8'h00;
    localparam logic [7:0]  OFS_X_START     = 8'h04;
    localparam logic [7:0]  OFS_X_END       = 8'h08;
    localparam logic [7:0]  OFS_Y_START     = 8'h0c;
    localparam logic [7:0]  OFS_Y_END       = 8'h10;
    localparam logic [7:0]  OFS_STATUS      = 8'h14;
    // control register fields
    localparam int unsigned X_SEL_LSB       = 0;
    localparam int unsigned Y_SEL_LSB       = 4;
    localparam int unsigned Y_EN_BIT        = 14;
    localparam int unsigned X_EN_BIT        = 15;
    localparam logic [3:0]  SEL_NONE        = 4'hf;
    // reset values
    localparam logic [15:0] CONTROL_RESET   = 16'h0000;
    localparam logic [15:0] BOUND_RESET     = 16'h0000;
    // largest buffer: 32K words, 64 Kbytes
    localparam logic [15:0] MAX_SPAN_BYTES  = 16'hfffe;
    // frame and stack pointers, not advised for selection
    localparam logic [3:0]  FRAME_PTR       = 4'he;
    localparam logic [3:0]  STACK_PTR       = 4'hf;
    localparam int unsigned N_REGS          = 6;
endpackage : circ_pkg

// ===== logic/circ_wrap.sv
// boundary wrap engine for one data space
`timescale 1ns/1ps
module circ_wrap #(
    parameter int unsigned AW        = 16,
    parameter bit          WORD_ONLY = 1'b0
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          active,
    input  wire logic [AW-1:0] start_addr,
    input  wire logic [AW-1:0] end_addr,
    input  wire logic [AW-1:0] ea_in,
    input  wire logic [AW-1:0] ea_step,
    input  wire logic          ea_dec,
    output logic      [AW-1:0] ea_out,
    output logic               wrapped
);
    logic [AW-1:0] next_ea_out;
    logic          next_wrapped;
    logic [AW-1:0] lo;
    logic [AW-1:0] hi;
    logic [AW-1:0] base;
    logic [AW:0]   sum;
    logic [AW-1:0] raw;

    // a one-bit address leaves no room for the word alignment bit
    if (AW < 2)
    begin : g_aw_check
        $error("circ_wrap address width below 2");
    end

    always_comb
    begin
        lo   = start_addr;
        hi   = end_addr;
        base = ea_in;
        if (WORD_ONLY)
        begin
            lo[0]   = 1'b0;  // R07
            hi[0]   = 1'b0;
            base[0] = 1'b0;
        end
        sum = ea_dec ? ({1'b0, base} - {1'b0, ea_step}) : ({1'b0, base} + {1'b0, ea_step});
        raw = sum[AW-1:0];
        if (WORD_ONLY)
            raw[0] = 1'b0;
        next_ea_out  = raw;
        next_wrapped = 1'b0;
        // both boundaries checked so power-of-two buffers run either way
        if (active && !ea_dec && (sum[AW] || raw > hi))  // R05
        begin
            next_ea_out  = lo;  // R15
            next_wrapped = 1'b1;
        end
        else if (active && ea_dec && (sum[AW] || raw < lo))  // R05
        begin
            next_ea_out  = hi;  // R15
            next_wrapped = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ea_out  <= '0;
            wrapped <= 1'b0;
        end
        else
        begin
            ea_out  <= next_ea_out;
            wrapped <= next_wrapped;
        end
    end
endmodule : circ_wrap

// ===== sim/agu_model.sv
// pointer register model of one core address generator
`timescale 1ns/1ps
module agu_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    input  wire logic        run,
    input  wire logic [15:0] next_in,
    output logic      [15:0] ea
);
    logic phase;
    logic next_phase;
    logic [15:0] next_ea;
    // one direction per walk, starts from load_val and takes next_in on every second run cycle
    always_comb
    begin
        next_phase = phase;
        next_ea = ea;
        if (load)
        begin
            next_phase = 1'b0;
            next_ea = load_val;
        end
        else if (run)
        begin
            next_phase = ~phase;
            if (phase)
                next_ea = next_in;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase <= 1'b0;
            ea <= 16'h0000;
        end
        else
        begin
            phase <= next_phase;
            ea <= next_ea;
        end
    end
endmodule : agu_model

// ===== sim/circ_addr_ctrl_tb.sv
// self-checking bench for the circular-buffer address control
`timescale 1ns/1ps
module circ_addr_ctrl_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf, x_rd_ptr = 4'h3, x_wr_ptr = 4'h3, y_ptr = 4'h3;
    logic pready, pslverr, x_rd_prog = 0, x_rd_dec = 0, x_wr_dec = 0, y_dec = 0;
    logic [15:0] x_rd_ea = 0, x_rd_step = 16'h2, x_wr_ea, x_wr_step = 16'h2, y_ea, y_step = 16'h2;
    logic [15:0] x_rd_next, x_wr_next, y_next, wl_val = 0, yl_val = 0;
    logic x_rd_wrapped, x_wr_wrapped, y_wrapped, x_active, y_active, wl = 0, yl = 0, run = 0;
    int n_errors = 0, total_checks = 0;
    always #20 pclk = ~pclk;
    circ_addr_ctrl i_circ_addr_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .x_rd_ptr(x_rd_ptr), .x_rd_prog(x_rd_prog), .x_rd_ea(x_rd_ea),
        .x_rd_step(x_rd_step), .x_rd_dec(x_rd_dec), .x_rd_next(x_rd_next), .x_rd_wrapped(x_rd_wrapped),
        .x_wr_ptr(x_wr_ptr), .x_wr_ea(x_wr_ea), .x_wr_step(x_wr_step), .x_wr_dec(x_wr_dec),
        .x_wr_next(x_wr_next), .x_wr_wrapped(x_wr_wrapped), .y_ptr(y_ptr), .y_ea(y_ea), .y_step(y_step),
        .y_dec(y_dec), .y_next(y_next), .y_wrapped(y_wrapped), .x_active(x_active), .y_active(y_active));
    agu_model i_agu_model_xw (.pclk(pclk), .presetn(presetn), .load(wl), .load_val(wl_val), .run(run),
        .next_in(x_wr_next), .ea(x_wr_ea));
    agu_model i_agu_model_y (.pclk(pclk), .presetn(presetn), .load(yl), .load_val(yl_val), .run(run),
        .next_in(y_next), .ea(y_ea));
    task complete_run;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : complete_run
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk(pready, 1'b1, "no ready");
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk(e, xe, "write error flag");
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        chk(r, x, "read data");
        chk(e, xe, "read error flag");
    endtask : rd
    task gen_x(input logic [3:0] p, input logic [15:0] ea, input logic dc, input logic pg,
               input logic [15:0] x, input logic xw);
        @(posedge pclk);
        x_rd_ptr <= p;
        x_rd_ea <= ea;
        x_rd_dec <= dc;
        x_rd_prog <= pg;
        @(posedge pclk);
        #1;
        chk(x_rd_next, x, "x next");
        chk(x_rd_wrapped, xw, "x wrapped");
    endtask : gen_x
    task gen_y(input logic [15:0] ea, input logic dc, input logic [15:0] x, input logic xw);
        @(posedge pclk);
        yl <= 1'b1;
        yl_val <= ea;
        y_dec <= dc;
        @(posedge pclk);
        yl <= 1'b0;
        @(posedge pclk);
        #1;
        chk(y_next, x, "y next");
        chk(y_wrapped, xw, "y wrapped");
    endtask : gen_y
    task gen_xw(input logic [15:0] ea, input logic dc, input logic [15:0] x, input logic xw);
        @(posedge pclk);
        wl <= 1'b1;
        wl_val <= ea;
        x_wr_dec <= dc;
        @(posedge pclk);
        wl <= 1'b0;
        @(posedge pclk);
        #1;
        chk(x_wr_next, x, "x write next");
        chk(x_wr_wrapped, xw, "x write wrapped");
    endtask : gen_xw
    task walk(input logic [15:0] xs, input logic [15:0] ys);
        @(posedge pclk);
        wl <= 1'b1;
        wl_val <= xs;
        yl <= 1'b1;
        yl_val <= ys;
        @(posedge pclk);
        wl <= 1'b0;
        yl <= 1'b0;
        run <= 1'b1;
        repeat (8) @(posedge pclk);
        run <= 1'b0;
        #1;
    endtask : walk
    task test_regs;
        rd(circ_pkg::OFS_CONTROL, 32'h0, 1'b0);
        rd(circ_pkg::OFS_Y_END, 32'h0, 1'b0);
        wr(circ_pkg::OFS_X_START, 32'hffff_1000, 1'b0);
        rd(circ_pkg::OFS_X_START, 32'h0000_1000, 1'b0);
        wr(circ_pkg::OFS_X_END, 32'h1006, 1'b0);
        wr(circ_pkg::OFS_Y_START, 32'h2000, 1'b0);
        wr(circ_pkg::OFS_Y_END, 32'h2007, 1'b0);
        rd(circ_pkg::OFS_Y_END, 32'h2007, 1'b0);
        rd(circ_pkg::OFS_STATUS, 32'h0006_000c, 1'b0);
        rd(8'h18, 32'h0, 1'b1);
        wr(circ_pkg::OFS_STATUS, 32'h1, 1'b1);
        $display("test regs done");
    endtask : test_regs
    task test_enables;
        logic [15:0] c [4] = '{16'hc033, 16'h0033, 16'hc0ff, 16'h8033};
        logic xo [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        logic yo [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
        for (int i = 0; i < 4; i++)
        begin
            wr(circ_pkg::OFS_CONTROL, {16'h0, c[i]}, 1'b0);
            rd(circ_pkg::OFS_CONTROL, {16'h0, c[i]}, 1'b0);
            gen_x(4'h3, 16'h1006, 1'b0, 1'b0, xo[i] ? 16'h1000 : 16'h1008, xo[i]);
            gen_y(16'h2006, 1'b0, yo[i] ? 16'h2000 : 16'h2008, yo[i]);
            chk(x_active, xo[i], "x active");
            chk(y_active, yo[i], "y active");
        end
        $display("test enables done");
    endtask : test_enables
    task test_wrap;
        wr(circ_pkg::OFS_CONTROL, 32'hc033, 1'b0);
        gen_x(4'h3, 16'h1000, 1'b1, 1'b0, 16'h1006, 1'b1);
        gen_x(4'h3, 16'h1004, 1'b0, 1'b1, 16'h1006, 1'b0);
        gen_x(4'h3, 16'h1006, 1'b0, 1'b1, 16'h1000, 1'b1);
        gen_x(4'h4, 16'h1006, 1'b0, 1'b0, 16'h1008, 1'b0);
        gen_y(16'h2003, 1'b0, 16'h2004, 1'b0);
        gen_y(16'h2000, 1'b1, 16'h2006, 1'b1);
        gen_xw(16'h1000, 1'b1, 16'h1006, 1'b1);
        gen_xw(16'h1004, 1'b1, 16'h1002, 1'b0);
        gen_xw(16'h1006, 1'b0, 16'h1000, 1'b1);
        walk(16'h1002, 16'h2004);
        chk(x_wr_ea, 16'h1002, "x walk");
        chk(y_ea, 16'h2004, "y walk");
        wr(circ_pkg::OFS_CONTROL, 32'hc03f, 1'b0);
        walk(16'h1002, 16'h2004);
        chk(x_wr_ea, 16'h100a, "x walk off");
        chk(y_ea, 16'h2004, "y walk on");
        wr(circ_pkg::OFS_CONTROL, 32'hc033, 1'b0);
        wr(circ_pkg::OFS_X_START, 32'h0, 1'b0);
        wr(circ_pkg::OFS_X_END, 32'hfffe, 1'b0);
        gen_x(4'h3, 16'hfffe, 1'b0, 1'b0, 16'h0000, 1'b1);
        gen_x(4'h3, 16'h0000, 1'b1, 1'b0, 16'hfffe, 1'b1);
        $display("test wrap done");
    endtask : test_wrap
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        test_regs();
        test_enables();
        test_wrap();
        complete_run();
    end
    initial
    begin
        #400000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        complete_run();
    end
endmodule : circ_addr_ctrl_tb
